// ==== core/uart_flag_defs.svh ====
// Register offsets, field positions and reset values of the flag block.
// Included by the flag modules; definitions only.
`ifndef UART_FLAG_DEFS_SVH
`define UART_FLAG_DEFS_SVH
// Byte offsets on the Wishbone bus
`define OFS_LINE_STATUS 8'h00
`define OFS_SHARED_DATA 8'h04
`define OFS_CONTROL     8'h08
`define OFS_IRQ_STATUS  8'h0C
`define OFS_IRQ_MASK    8'h10
// Line status field positions
`define LS_TX_EMPTY     0
`define LS_TX_IDLE      1
`define LS_RX_AVAIL     2
`define LS_RX_IDLE      3
`define LS_OVERRUN      4
`define LS_FRAMING      5
`define LS_NOISE        6
`define LS_PARITY       7
// Control field positions
`define CTL_PORT_EN     0
`define CTL_TX_EN       1
`define CTL_RX_IE       2
// Interrupt status field positions
`define IRQ_RX_DATA     0
`define IRQ_OVERRUN     1
`define IRQ_TX_EMPTY    2
`define IRQ_TX_IDLE     3
// Widths and reset values
`define LS_WIDTH        8
`define IRQ_WIDTH       4
`define FIFO_DEPTH      2
`define CTL_RESET       3'h0
`define IRQ_RESET       4'h0
`define MASK_RESET      4'h0
`define DATA_RESET      8'h00
`endif

// ==== core/uart_flag_pkg.sv ====
// Types shared by the flag block and its receive buffer.
// Assumes the defines header is on the include path.
package uart_flag_pkg;
  // One received character with its error marks
  typedef struct packed {
    logic [7:0] data;
    logic       noise;
    logic       framing;
    logic       parity;
  } rx_word_t;

  // Software control bits
  typedef struct packed {
    logic rx_ie;
    logic tx_en;
    logic port_en;
  } ctrl_t;
endpackage : uart_flag_pkg

// ==== core/rx_fifo.sv ====
// Two-entry receive buffer that sits behind the shared data register.
// Assumes push is never given while full; the caller checks.
`timescale 1ns/1ps
`include "uart_flag_defs.svh"
module rx_fifo
  import uart_flag_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  // Control
  input  wire logic     flush_i,
  input  wire logic     push_i,
  input  wire rx_word_t push_word_i,
  input  wire logic     pop_i,
  // State
  output rx_word_t      head_o,
  output logic          empty_o,
  output logic          full_o
);
  rx_word_t mem [`FIFO_DEPTH];
  logic     wr_ptr;
  logic     rd_ptr;
  logic [1:0] count;

  assign head_o  = mem[rd_ptr];
  assign empty_o = (count == 2'd0);
  assign full_o  = (count == 2'd2);

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push_i) begin
        mem[wr_ptr] <= push_word_i;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop_i && !empty_o) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push_i} - {1'b0, pop_i && !empty_o};
    end
  end
endmodule : rx_fifo

// ==== core/clear_tracker.sv ====
// Remembers, per flag, that a status read saw it set, and fires a clear
// on the next qualifying data register access. Assumes same-clock inputs.
`timescale 1ns/1ps
module clear_tracker #(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Bus events
  input  wire logic         status_rd_i,
  input  wire logic [N-1:0] flag_i,
  input  wire logic [N-1:0] access_i,
  // Clear pulses
  output logic      [N-1:0] clr_o
);
  logic [N-1:0] armed;

  for (genvar i = 0; i < N; i++) begin : g_flag
    // R18: record then clear
    assign clr_o[i] = armed[i] & access_i[i];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        armed[i] <= 1'b0;
      end else if (status_rd_i) begin
        armed[i] <= flag_i[i];
      end else if (access_i[i]) begin
        armed[i] <= 1'b0;
      end
    end
  end
endmodule : clear_tracker

// ==== core/uart_status_flag_logic.sv ====
// Status flags of the serial port with a classic Wishbone register slave.
// Assumes the shift logic runs on clk_i and gives one-cycle event pulses.
//
// Summary of operation
// R1: Receive into full buffer sets overrun; overrun blocks further stores.
// R2: Overrun clears after status read then shared data access.
// R3: Receiver idle is 0 from start bit to stop bit end.
// R4: Character moved into data register sets receive available flag.
// R5: Receive transfer raises interrupt request only when enable bit is 1.
// R6: Noise, framing, parity flags set in same cycle as available.
// R7: Available clears after status read, data read, buffer then empty.
// R8: Transmitter idle high when empty flag set and nothing shifting.
// R9: Transmitter idle clears on status read then data write.
// R10: Transmitter idle stays low while data or break is queued.
// R11: Transmit empty set when shift register takes the character.
// R12: Transmit empty clears on status read then data write.
// R13: Setting transmitter enable sets the transmit empty flag.
// R14: Received characters wait in a two-entry buffer.
// R15: No noise flag for a character lost to overrun.
// R16: Disable flushes buffer, clears errors, forces idle and empty high.
// R17: One shared data address: reads receive, writes transmit.
// R18: Each clear is armed by status read, fired by next access.
`timescale 1ns/1ps
`include "uart_flag_defs.svh"
module uart_status_flag_logic
  import uart_flag_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Receive shift logic
  input  wire logic        rx_start_i,
  input  wire logic        rx_stop_done_i,
  input  wire logic        rx_xfer_i,
  input  wire rx_word_t    rx_word_i,
  // Transmit shift logic
  input  wire logic        tx_load_i,
  input  wire logic        tx_busy_i,
  input  wire logic        break_queued_i,
  output logic      [7:0]  tx_data_o,
  output logic             tx_pending_o,
  // Control outputs
  output logic             port_enable_o,
  output logic             tx_enable_o,
  // Interrupts
  output logic             rx_irq_o,
  output logic             irq_o
);
  ctrl_t ctrl;
  logic  tx_en_q;
  logic  overrun;
  logic  noise_err;
  logic  framing_err;
  logic  parity_err;
  logic  rx_idle;
  logic  tx_idle;
  logic  tx_empty;
  logic  [`IRQ_WIDTH-1:0] irq_status;
  logic  [`IRQ_WIDTH-1:0] irq_mask;
  logic  [`LS_WIDTH-1:0]  line_status;
  logic  [`LS_WIDTH-1:0]  access;
  logic  [`LS_WIDTH-1:0]  clr;
  rx_word_t head;
  logic  fifo_empty;
  logic  fifo_full;

  // Bus decode
  wire req       = cyc_i & stb_i & ~ack_o;
  wire rd        = req & ~we_i;
  wire wr        = req & we_i & sel_i[0];
  wire hit_ls    = (adr_i == `OFS_LINE_STATUS);
  wire hit_data  = (adr_i == `OFS_SHARED_DATA);
  wire hit_ctl   = (adr_i == `OFS_CONTROL);
  wire hit_irq   = (adr_i == `OFS_IRQ_STATUS);
  wire hit_mask  = (adr_i == `OFS_IRQ_MASK);
  wire status_rd = rd & hit_ls;
  wire data_rd   = rd & hit_data;
  wire data_wr   = wr & hit_data;
  wire data_acc  = req & hit_data;
  wire irq_rd    = rd & hit_irq;
  wire port_en   = ctrl.port_en;

  // R14: two-entry receive buffer
  // R4: available while data unread
  wire rx_avail = ~fifo_empty;
  // R1: store only while room and no overrun
  wire push     = port_en & rx_xfer_i & ~fifo_full & ~overrun;
  wire ovr_set  = port_en & rx_xfer_i & fifo_full;
  // R7: pop only on an armed data read
  wire pop      = clr[`LS_RX_AVAIL];
  wire tx_en_up = ctrl.tx_en & ~tx_en_q;
  // R10: a queued character or break keeps idle low
  wire tx_quiet = tx_empty & ~tx_busy_i & ~break_queued_i & ~tx_pending_o & ~data_wr;

  // R16: disable flushes buffer
  rx_fifo u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (~port_en),
    .push_i      (push),
    .push_word_i (rx_word_i),
    .pop_i       (pop),
    .head_o      (head),
    .empty_o     (fifo_empty),
    .full_o      (fifo_full)
  );

  // Line status layout
  assign line_status[`LS_TX_EMPTY] = tx_empty;
  assign line_status[`LS_TX_IDLE]  = tx_idle;
  assign line_status[`LS_RX_AVAIL] = rx_avail;
  assign line_status[`LS_RX_IDLE]  = rx_idle;
  assign line_status[`LS_OVERRUN]  = overrun;
  assign line_status[`LS_FRAMING]  = framing_err;
  assign line_status[`LS_NOISE]    = noise_err;
  assign line_status[`LS_PARITY]   = parity_err;

  // R2: overrun and errors clear on any data access
  assign access[`LS_TX_EMPTY] = data_wr;
  assign access[`LS_TX_IDLE]  = data_wr;
  assign access[`LS_RX_AVAIL] = data_rd;
  assign access[`LS_RX_IDLE]  = 1'b0;
  assign access[`LS_OVERRUN]  = data_acc;
  assign access[`LS_FRAMING]  = data_acc;
  assign access[`LS_NOISE]    = data_acc;
  assign access[`LS_PARITY]   = data_acc;

  clear_tracker #(
    .N (`LS_WIDTH)
  ) u_clear_tracker (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .status_rd_i (status_rd),
    .flag_i      (line_status),
    .access_i    (access),
    .clr_o       (clr)
  );

  // Read mux; unmapped offsets read zero
  wire [31:0] rd_word =
    hit_ls   ? {24'h00_0000, line_status} :
    hit_data ? {24'h00_0000, head.data} :
    hit_ctl  ? {29'h000_0000, ctrl} :
    hit_irq  ? {28'h000_0000, irq_status} :
    hit_mask ? {28'h000_0000, irq_mask} : 32'h0000_0000;

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= rd ? rd_word : 32'h0000_0000;
    end
  end

  // Control register; disable also drops transmit enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= `CTL_RESET;
      tx_en_q <= 1'b0;
    end else begin
      tx_en_q <= ctrl.tx_en;
      if (wr && hit_ctl) begin
        ctrl.port_en <= dat_i[`CTL_PORT_EN];
        ctrl.tx_en   <= dat_i[`CTL_TX_EN] & dat_i[`CTL_PORT_EN];
        ctrl.rx_ie   <= dat_i[`CTL_RX_IE];
      end else if (!ctrl.port_en) begin
        ctrl.tx_en <= 1'b0;
      end
    end
  end

  assign port_enable_o = ctrl.port_en;
  assign tx_enable_o   = ctrl.tx_en;

  // R1: overrun flag, set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      overrun <= 1'b0;
    end else if (ovr_set) begin
      overrun <= 1'b1;
    end else if (clr[`LS_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end

  // R6: error marks load with the stored character
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      noise_err   <= 1'b0;
      framing_err <= 1'b0;
      parity_err  <= 1'b0;
    end else begin
      // R15: lost characters never reach here
      if (push && rx_word_i.noise) begin
        noise_err <= 1'b1;
      end else if (clr[`LS_NOISE]) begin
        noise_err <= 1'b0;
      end
      if (push && rx_word_i.framing) begin
        framing_err <= 1'b1;
      end else if (clr[`LS_FRAMING]) begin
        framing_err <= 1'b0;
      end
      if (push && rx_word_i.parity) begin
        parity_err <= 1'b1;
      end else if (clr[`LS_PARITY]) begin
        parity_err <= 1'b0;
      end
    end
  end

  // R3: receiver idle from stop end to next start
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      rx_idle <= 1'b1;
    end else if (rx_start_i) begin
      rx_idle <= 1'b0;
    end else if (rx_stop_done_i) begin
      rx_idle <= 1'b1;
    end
  end

  // R17: writes to the shared address load the transmit side
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      tx_data_o    <= `DATA_RESET;
      tx_pending_o <= 1'b0;
    end else if (data_wr) begin
      tx_data_o    <= dat_i[7:0];
      tx_pending_o <= 1'b1;
    end else if (tx_load_i) begin
      tx_pending_o <= 1'b0;
    end
  end

  // R11: shift register took the character
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      tx_empty <= 1'b1;
    // R13: enabling the transmitter
    end else if (tx_load_i || tx_en_up) begin
      tx_empty <= 1'b1;
    // R12: armed data write clears
    end else if (clr[`LS_TX_EMPTY]) begin
      tx_empty <= 1'b0;
    end
  end

  // R8: idle when empty and nothing shifting
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en) begin
      tx_idle <= 1'b1;
    end else if (tx_quiet) begin
      tx_idle <= 1'b1;
    // R9: armed data write clears
    end else if (clr[`LS_TX_IDLE] || tx_busy_i || break_queued_i) begin
      tx_idle <= 1'b0;
    end
  end

  // R5: request only with receive interrupt enabled
  wire rx_req = push & ctrl.rx_ie;

  // Sticky events; an interrupt status read clears, a new event wins
  wire [`IRQ_WIDTH-1:0] irq_event = {tx_quiet & ~tx_idle & port_en,
                                     tx_load_i & ~tx_empty & port_en,
                                     ovr_set & ~overrun,
                                     rx_req};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_irq_o   <= 1'b0;
      irq_status <= `IRQ_RESET;
      irq_mask   <= `MASK_RESET;
    end else begin
      rx_irq_o   <= rx_req;
      irq_status <= (irq_rd ? `IRQ_RESET : irq_status) | irq_event;
      if (wr && hit_mask) begin
        irq_mask <= dat_i[`IRQ_WIDTH-1:0];
      end
    end
  end

  // Level output straight from the sticky bits and mask
  assign irq_o = |(irq_status & irq_mask);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_overrun_set_full: assert property ( // R1
    port_en && rx_xfer_i && fifo_full |=> overrun)
    else $error("overrun not set on full buffer");

  a_overrun_blocks_store: assert property ( // R1
    port_en && overrun && !pop |=> $stable(fifo_empty) && $stable(fifo_full))
    else $error("buffer changed during overrun");

  a_overrun_clear_seq: assert property ( // R2
    $fell(overrun) && $past(port_en) |-> $past(data_acc))
    else $error("overrun cleared without data access");

  a_rx_idle_start: assert property ( // R3
    port_en && rx_start_i ##1 port_en && !rx_stop_done_i |-> !rx_idle)
    else $error("receiver idle during character");

  a_avail_after_push: assert property ( // R4
    push |=> rx_avail)
    else $error("available flag not set after transfer");

  a_rx_irq_gate: assert property ( // R5
    rx_irq_o |-> $past(push) && $past(ctrl.rx_ie))
    else $error("receive request without enabled transfer");

  a_error_same_cycle: assert property ( // R6
    push && rx_word_i.parity |=> parity_err && rx_avail)
    else $error("parity flag not set with available");

  a_avail_clear_seq: assert property ( // R7
    $fell(rx_avail) && $past(port_en) |-> $past(clr[`LS_RX_AVAIL]))
    else $error("available cleared without armed read");

  a_tx_idle_queued: assert property ( // R10
    port_en && (tx_busy_i || break_queued_i) && !tx_quiet |=> !tx_idle)
    else $error("idle while shifting or break queued");

  a_tx_empty_load: assert property ( // R11
    port_en && tx_load_i ##1 port_en |-> tx_empty)
    else $error("empty flag not set on load");

  a_tx_enable_empty: assert property ( // R13
    port_en && $rose(ctrl.tx_en) |=> tx_empty)
    else $error("empty flag not set on transmitter enable");

  a_disable_forces: assert property ( // R16
    !port_en |=> rx_idle && tx_idle && tx_empty && !overrun && !rx_avail)
    else $error("disable did not reset flags");

endmodule : uart_status_flag_logic

// ==== testbench/serial_peer.sv ====
// Behavioural shift logic and remote serial peer for the flag block.
// Assumes the bench calls its receive tasks and that all timing is on clk_i.
`timescale 1ns/1ps
module serial_peer
  import uart_flag_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Receive side
  output rx_word_t        rx_word_o,
  output logic            rx_start_o,
  output logic            rx_stop_done_o,
  output logic            rx_xfer_o,
  // Transmit side
  input  wire logic       tx_pending_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_load_o,
  output logic            tx_busy_o,
  output logic            break_queued_o
);
  logic [7:0] tx_q[$];
  int         lat;
  initial begin
    rx_word_o = '0;
    {rx_start_o, rx_stop_done_o, rx_xfer_o} = 3'h0;
    {tx_load_o, tx_busy_o, break_queued_o} = 3'h0;
  end
  task automatic begin_frame();
    @(posedge clk_i);
    rx_start_o <= 1'b1;
    @(posedge clk_i);
    rx_start_o <= 1'b0;
  endtask : begin_frame
  // Word is inverted once released so a stale value is never trusted
  task automatic end_frame(input rx_word_t w);
    @(posedge clk_i);
    rx_word_o <= w;
    {rx_stop_done_o, rx_xfer_o} <= 2'h3;
    @(posedge clk_i);
    rx_word_o <= ~w;
    {rx_stop_done_o, rx_xfer_o} <= 2'h0;
  endtask : end_frame
  task automatic set_break(input logic b);
    @(posedge clk_i);
    break_queued_o <= b;
  endtask : set_break
  // load only while pending, prompt or slow
  always begin
    @(posedge clk_i);
    if (tx_pending_i === 1'b1) begin
      lat = $urandom_range(8, 3);
      repeat (lat) @(posedge clk_i);
      {tx_load_o, tx_busy_o} <= 2'h3;
      tx_q.push_back(tx_data_i);
      @(posedge clk_i);
      tx_load_o <= 1'b0;
      repeat (20) @(posedge clk_i);
      tx_busy_o <= 1'b0;
    end
  end
endmodule : serial_peer

// ==== testbench/testbench.sv ====
// Self-checking bench of the flag block with a queue model of the receive path.
// Assumes the peer model on the shift side and a classic Wishbone master here.
`timescale 1ns/1ps
`include "uart_flag_defs.svh"
module testbench
  import uart_flag_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o, q;
  logic        ack_o, rx_start_i, rx_stop_done_i, rx_xfer_i, tx_load_i, tx_busy_i;
  logic        break_queued_i, tx_pending_o, port_enable_o, tx_enable_o, rx_irq_o, irq_o;
  logic [7:0]  tx_data_o, tb, m_q[$];
  rx_word_t    rx_word_i, w;
  logic [2:0]  m_err = 3'h0;
  logic        m_ovr = 1'b0, m_en = 1'b0;
  int          n_mismatch = 0, cmp_count = 0, irq_cnt = 0, n;

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (!rst_i && rx_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;

  uart_status_flag_logic uart_status_flag_logic_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rx_start_i, .rx_stop_done_i,
    .rx_xfer_i, .rx_word_i, .tx_load_i, .tx_busy_i, .break_queued_i, .tx_data_o,
    .tx_pending_o, .port_enable_o, .tx_enable_o, .rx_irq_o, .irq_o);
  serial_peer serial_peer_inst (.clk_i, .rx_word_o(rx_word_i), .rx_start_o(rx_start_i),
    .rx_stop_done_o(rx_stop_done_i), .rx_xfer_o(rx_xfer_i), .tx_pending_i(tx_pending_o),
    .tx_data_i(tx_data_o), .tx_load_o(tx_load_i), .tx_busy_o(tx_busy_i),
    .break_queued_o(break_queued_i));

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic give_up(input logic hit);
    if (hit) begin
      n_mismatch++;
      $display("[FAIL] wait expected done seen timeout");
      stop_test();
    end
  endtask : give_up

  // Request held until ack is sampled high, then released
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, wr, a, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    give_up(ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000);
    check(nm, q, e);
  endtask : rd

  function automatic logic [31:0] exp_ls(input logic [1:0] tx);
    return {24'h00_0000, m_err, m_ovr, 1'b1, m_q.size() > 0, tx};
  endfunction : exp_ls

  // Model stores up to two words; a third sets overrun with no error marks
  task automatic rx_char(input rx_word_t x);
    serial_peer_inst.begin_frame();
    rd(`OFS_LINE_STATUS, exp_ls(2'b11) & 32'hFFFF_FFF7, "rx_busy");
    serial_peer_inst.end_frame(x);
    if (m_en && !m_ovr && m_q.size() < `FIFO_DEPTH) begin
      m_q.push_back(x.data);
      m_err = m_err | {x.parity, x.noise, x.framing};
    end else if (m_en) begin
      m_ovr = 1'b1;
    end
  endtask : rx_char

  // Always preceded by a status read, so the error and overrun flags seen set are cleared
  task automatic data_rd();
    wb(1'b0, `OFS_SHARED_DATA, 32'h0000_0000);
    check("rx_data", q, {24'h00_0000, m_q.pop_front()});
    m_err = 3'h0;
    m_ovr = 1'b0;
  endtask : data_rd

  initial begin
    void'($urandom(17));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFS_LINE_STATUS, 32'h0000_000B, "line_status");
    rd(`OFS_CONTROL, 32'h0000_0000, "control");
    rd(`OFS_IRQ_MASK, 32'h0000_0000, "irq_mask");
    rd(8'h20, 32'h0000_0000, "unmapped");
    $display("test reset done");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0007);
    m_en = 1'b1;
    check("port_enable", port_enable_o, 32'h0000_0001);
    check("tx_enable", tx_enable_o, 32'h0000_0001);
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    rx_char({8'($urandom), 3'b011});
    rx_char({8'($urandom), 3'b000});
    rx_char({8'($urandom), 3'b100});
    check("rx_irq_count", irq_cnt, 32'h0000_0002);
    check("irq_masked", irq_o, 32'h0000_0000);
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    data_rd();
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    data_rd();
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    wb(1'b1, `OFS_IRQ_MASK, 32'h0000_000F);
    check("irq_level", irq_o, 32'h0000_0001);
    rd(`OFS_IRQ_STATUS, 32'h0000_0003, "irq_status");
    check("irq_cleared", irq_o, 32'h0000_0000);
    rd(`OFS_IRQ_STATUS, 32'h0000_0000, "irq_status");
    $display("test receive done");
    tb = 8'($urandom);
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    wb(1'b1, `OFS_SHARED_DATA, {24'h00_0000, tb});
    check("tx_pending", tx_pending_o, 32'h0000_0001);
    check("tx_data", tx_data_o, tb);
    rd(`OFS_LINE_STATUS, exp_ls(2'b00), "line_status");
    for (n = 0; n < 60 && tx_pending_o !== 1'b0; n++) @(posedge clk_i);
    give_up(n >= 60);
    rd(`OFS_LINE_STATUS, exp_ls(2'b01), "line_status");
    serial_peer_inst.set_break(1'b1);
    for (n = 0; n < 60 && tx_busy_i !== 1'b0; n++) @(posedge clk_i);
    give_up(n >= 60);
    rd(`OFS_LINE_STATUS, exp_ls(2'b01), "line_status");
    serial_peer_inst.set_break(1'b0);
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    rd(`OFS_IRQ_STATUS, 32'h0000_000C, "irq_status");
    check("tx_char", serial_peer_inst.tx_q[0], tb);
    $display("test transmit done");
    rx_char({8'($urandom), 3'b111});
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0000);
    {m_en, m_ovr, m_err} = 5'h00;
    m_q.delete();
    check("port_tx_enable", {port_enable_o, tx_enable_o}, 32'h0000_0000);
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    wb(1'b1, `OFS_CONTROL, 32'h0000_0003);
    m_en = 1'b1;
    n = irq_cnt;
    rx_char({8'($urandom), 3'($urandom)});
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    check("rx_irq_off", irq_cnt, n);
    data_rd();
    rd(`OFS_LINE_STATUS, exp_ls(2'b11), "line_status");
    $display("test disable done");
    stop_test();
  end
endmodule : testbench
